// ==== micfg_pkg.sv ====
// shared constants for the interpolation config and status register group
package micfg_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_INTERP_MODE = 8'h00;
  localparam logic [7:0] OFF_DATA_LOW    = 8'h04;
  localparam logic [7:0] OFF_DATA_HIGH   = 8'h08;
  localparam logic [7:0] OFF_MAIN_STATUS = 8'h0C;
  localparam logic [7:0] OFF_AXIS_STAT1  = 8'h10;
  localparam logic [7:0] OFF_AXIS_STAT2  = 8'h14;
  localparam logic [7:0] OFF_COMMAND     = 8'h18;
  localparam logic [7:0] OFF_DLOW_BYTE0  = 8'h1C;
  localparam logic [7:0] OFF_DLOW_BYTE1  = 8'h20;
  localparam logic [7:0] OFF_DHIGH_BYTE0 = 8'h24;
  localparam logic [7:0] OFF_DHIGH_BYTE1 = 8'h28;

  localparam logic [15:0] INTERP_MODE_RESET = 16'h0000;

  // interpolation mode field positions
  localparam int MASTER_LSB  = 0;
  localparam int SECOND_LSB  = 2;
  localparam int THIRD_LSB   = 4;
  localparam int VSPEED_LSB  = 8;
  localparam int EXT_STEP_B  = 11;
  localparam int CMD_STEP_B  = 12;
  localparam int INTERP_IRQ_B = 14;
  localparam int BITPAT_IRQ_B = 15;
  localparam logic [15:0] INTERP_MODE_MASK = 16'hDB3F;

  localparam logic [1:0] VSPEED_OFF   = 2'b00;
  localparam logic [1:0] VSPEED_TWO   = 2'b01;
  localparam logic [1:0] VSPEED_BAD   = 2'b10;
  localparam logic [1:0] VSPEED_THREE = 2'b11;

  // command register: code in [7:0], axis mask in [11:8]
  localparam logic [7:0] CMD_FINISH_CLEAR = 8'h25;
  localparam logic [7:0] CMD_AXIS_SELECT  = 8'h1F;
  localparam int         CMD_MASK_LSB     = 8;

  // main status positions
  localparam int MS_ERR_LSB  = 4;
  localparam int MS_IDRV_B   = 8;
  localparam int MS_NEXT_NODE_READY_B  = 9;
  localparam int MS_ZONE_LSB = 10;
  localparam int MS_SC_LSB   = 13;

  // axis status one / two positions
  localparam int S1_ACCEL_DECREASING_FLAG_B    = 7;
  localparam int S1_CAUSE_LSB  = 8;
  localparam int S2_HOME_ERR_B = 7;
  localparam int S2_HSTATE_LSB = 8;
endpackage : micfg_pkg

// ==== micfg_regs.sv ====
// interpolation mode, command data staging and status registers over APB
//
// Behaviour
// - mode bits 1:0 pick the master axis, codes X=0 Y=1 Z=2 U=3
// - bits 3:2 and 5:4 pick second and third axes; third unused 2-axis
// - vector speed 00 off, 01 two-axis, 11 three-axis, 10 not allowed
// - one bit enables external step mode, another command step mode
// - separate interrupt enables for ordinary and bit-pattern interpolation
// - reset clears the whole interpolation mode register
// - operand halves staged in two 16-bit registers, any write order
// - in 8-bit bus mode each half is written as two bytes
// - operands are two's complement; software writes the needed length
// - drive flag is 1 while pulsing or home search, waits for in-position
// - axis error flag is OR of error bits and error-finish bits
// - flags for interpolation pulsing and ready for next node
// - three-bit octant of circular interpolation, binary 0 to 7
// - two-bit bit-pattern stack count, 3 full, 0 empty and finished
// - status one and two read the axis last selected by command
// - status bit shows acceleration magnitude decreasing in S-curve
// - finish-cause bits for four decel inputs, limits, alarm, emergency
// - finish causes and latched errors hold until drive or clear command; soft limit errors also clear when direction reverses
// - soft limit errors set only driving toward the limit past compare
// - error bits for hard limits, servo alarm and emergency low
// - home error if index active at step 3 start; five-bit home state
// - drive flag drops for one cycle after pulses end, then held until in-position if check enabled
`timescale 1ns/1ps
`default_nettype none
module micfg_regs #(
  parameter int AXES = 4,            // axes handled
  parameter int POS_W = 32           // position counter width
) (
  input  wire logic              clk,               // 20 MHz system clock
  input  wire logic              rst_n,             // sync reset, active low
  input  wire logic              psel,              // apb select
  input  wire logic              penable,           // apb access phase
  input  wire logic              pwrite,            // apb write
  input  wire logic [7:0]        paddr,             // apb byte address
  input  wire logic [31:0]       pwdata,            // apb write data
  output logic [31:0]            prdata,            // apb read data
  output logic                   pready,            // apb ready
  output logic                   pslverr,           // apb error
  input  wire logic [AXES-1:0]   in_position_in,    // pin, in-position
  input  wire logic [AXES-1:0]   servo_alarm_in,    // pin, servo alarm
  input  wire logic [AXES-1:0]   pos_limit_in,      // pin, + limit
  input  wire logic [AXES-1:0]   neg_limit_in,      // pin, - limit
  input  wire logic [AXES-1:0]   encoder_index_in,  // pin, index phase
  input  wire logic [4*AXES-1:0] decel_stop_inputs, // pin, decel stops
  input  wire logic              emergency_in_n,    // pin, emergency low
  input  wire logic              ext_step_pulse_in, // pin, step pulse
  input  wire logic              bus_8bit_in,       // pin, 8-bit bus mode
  input  wire logic [AXES-1:0]   inpos_check_en,    // axis mode, check on
  input  wire logic [AXES-1:0]   inpos_active_high, // axis mode, level
  input  wire logic [AXES-1:0]   alarm_check_en,    // axis mode, alarm on
  input  wire logic [AXES-1:0]   alarm_active_high, // axis mode, level
  input  wire logic [AXES-1:0]   limit_active_high, // axis mode, level
  input  wire logic [AXES-1:0]   soft_limit_en,     // axis mode, sw limit
  input  wire logic [AXES-1:0]   pulse_active,      // core, pulses out
  input  wire logic [AXES-1:0]   home_active,       // core, home search
  input  wire logic [AXES-1:0]   drive_dir_neg,     // core, direction
  input  wire logic [AXES-1:0]   drive_start,       // core, drive cmd
  input  wire logic [AXES-1:0]   drive_stop,        // core, drive ended
  input  wire logic [AXES-1:0]   home_step3_start,  // core, step 3 begins
  input  wire logic [5*AXES-1:0] home_search_state, // core, home state
  input  wire logic [AXES-1:0]   accel_decreasing,  // core, S-curve
  input  wire logic [AXES*POS_W-1:0] position,      // core, counters
  input  wire logic [AXES*POS_W-1:0] comp_pos,      // core, + compare
  input  wire logic [AXES*POS_W-1:0] comp_neg,      // core, - compare
  input  wire logic              interp_active,     // core, interp pulses
  input  wire logic              next_node_ready,   // core, next node ok
  input  wire logic [2:0]        circle_octant,     // core, octant
  input  wire logic [1:0]        stack_count,       // core, stack count
  output logic [1:0]             master_axis_sel,   // master axis code
  output logic [1:0]             second_axis_sel,   // second axis code
  output logic [1:0]             third_axis_sel,    // third axis code
  output logic [1:0]             vector_speed_mode, // vector speed mode
  output logic                   ext_step_mode_en,  // external step mode
  output logic                   cmd_step_mode_en,  // command step mode
  output logic                   interp_irq_en,     // interp irq enable
  output logic                   bitpat_irq_en,     // bit-pattern irq en
  output logic                   ext_step_advance,  // one step, pulse
  output logic [31:0]            cmd_operand,       // staged operand
  output logic [AXES-1:0]        limit_stop_req,    // stop on limit
  output logic [1:0]             selected_axis      // axis for status
);
  if (AXES != 4) $error("micfg_regs serves exactly four axes");
  if (POS_W < 2) $error("micfg_regs needs POS_W of at least 2");

  localparam int PIN_W = 9 * AXES + 3;

  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [15:0]      interp_mode_reg;
  logic [15:0]      data_low_reg;
  logic [15:0]      data_high_reg;
  logic [1:0]       sel_axis_reg;
  logic             step_prev_reg;
  logic [AXES-1:0]  inpos_wait_reg;
  logic [AXES-1:0]  pulse_prev_reg;
  logic [7:0]       cause_reg [AXES];
  logic [7:0]       err_reg [AXES];
  logic [31:0]      prdata_reg;

  logic [AXES-1:0] s_inpos, s_alarm, s_plim, s_nlim, s_index;
  logic [4*AXES-1:0] s_decel;
  logic s_emg_n, s_step, s_bus8;

  // pins cross into clk here; only the second stage is read below
  always_ff @(posedge clk)
  begin
    pin_meta_reg <= {ext_step_pulse_in, bus_8bit_in, emergency_in_n,
                     decel_stop_inputs, encoder_index_in, neg_limit_in,
                     pos_limit_in, servo_alarm_in, in_position_in};
    pin_sync_reg <= pin_meta_reg;
  end
  assign {s_step, s_bus8, s_emg_n, s_decel, s_index, s_nlim, s_plim,
          s_alarm, s_inpos} = pin_sync_reg;

  logic       wr_en, rd_setup, bad_addr, bad_vspeed;
  logic [7:0] cmd_code;
  logic [AXES-1:0] cmd_mask, clear_hit;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_code = pwdata[7:0];
  assign cmd_mask = pwdata[micfg_pkg::CMD_MASK_LSB +: AXES];
  assign bad_vspeed = pwdata[micfg_pkg::VSPEED_LSB +: 2]
                      == micfg_pkg::VSPEED_BAD;

  always_comb
  begin
    unique case (paddr)
      micfg_pkg::OFF_INTERP_MODE, micfg_pkg::OFF_DATA_LOW,
      micfg_pkg::OFF_DATA_HIGH, micfg_pkg::OFF_MAIN_STATUS,
      micfg_pkg::OFF_AXIS_STAT1, micfg_pkg::OFF_AXIS_STAT2,
      micfg_pkg::OFF_COMMAND: bad_addr = 1'b0;
      micfg_pkg::OFF_DLOW_BYTE0, micfg_pkg::OFF_DLOW_BYTE1,
      micfg_pkg::OFF_DHIGH_BYTE0, micfg_pkg::OFF_DHIGH_BYTE1:
        bad_addr = !s_bus8;
      default: bad_addr = 1'b1;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && (bad_addr ||
                   (pwrite && paddr == micfg_pkg::OFF_INTERP_MODE &&
                    bad_vspeed));
  assign prdata  = prdata_reg;

  // illegal vector speed code keeps the previous mode, rest still lands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      interp_mode_reg <= micfg_pkg::INTERP_MODE_RESET;
    else if (wr_en && paddr == micfg_pkg::OFF_INTERP_MODE)
    begin
      interp_mode_reg <= pwdata[15:0] & micfg_pkg::INTERP_MODE_MASK;
      if (bad_vspeed)
        interp_mode_reg[micfg_pkg::VSPEED_LSB +: 2] <=
          interp_mode_reg[micfg_pkg::VSPEED_LSB +: 2];
    end
  end

  assign master_axis_sel   = interp_mode_reg[micfg_pkg::MASTER_LSB +: 2];
  assign second_axis_sel   = interp_mode_reg[micfg_pkg::SECOND_LSB +: 2];
  assign third_axis_sel    = interp_mode_reg[micfg_pkg::THIRD_LSB +: 2];
  assign vector_speed_mode = interp_mode_reg[micfg_pkg::VSPEED_LSB +: 2];
  assign ext_step_mode_en  = interp_mode_reg[micfg_pkg::EXT_STEP_B];
  assign cmd_step_mode_en  = interp_mode_reg[micfg_pkg::CMD_STEP_B];
  assign interp_irq_en     = interp_mode_reg[micfg_pkg::INTERP_IRQ_B];
  assign bitpat_irq_en     = interp_mode_reg[micfg_pkg::BITPAT_IRQ_B];

  // data halves have no reset; order of writes does not matter
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      unique case (paddr)
        micfg_pkg::OFF_DATA_LOW:  data_low_reg  <= pwdata[15:0];
        micfg_pkg::OFF_DATA_HIGH: data_high_reg <= pwdata[15:0];
        micfg_pkg::OFF_DLOW_BYTE0:
          if (s_bus8) data_low_reg[7:0]   <= pwdata[7:0];
        micfg_pkg::OFF_DLOW_BYTE1:
          if (s_bus8) data_low_reg[15:8]  <= pwdata[7:0];
        micfg_pkg::OFF_DHIGH_BYTE0:
          if (s_bus8) data_high_reg[7:0]  <= pwdata[7:0];
        micfg_pkg::OFF_DHIGH_BYTE1:
          if (s_bus8) data_high_reg[15:8] <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  assign cmd_operand = {data_high_reg, data_low_reg};

  logic cmd_wr;
  assign cmd_wr    = wr_en && paddr == micfg_pkg::OFF_COMMAND;
  assign clear_hit = (cmd_wr && cmd_code == micfg_pkg::CMD_FINISH_CLEAR)
                     ? cmd_mask : '0;

  // lowest axis in the mask wins when several are named
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sel_axis_reg <= 2'b00;
    else if (cmd_wr && cmd_code == micfg_pkg::CMD_AXIS_SELECT &&
             |cmd_mask)
    begin
      if (cmd_mask[0])      sel_axis_reg <= 2'd0;
      else if (cmd_mask[1]) sel_axis_reg <= 2'd1;
      else if (cmd_mask[2]) sel_axis_reg <= 2'd2;
      else                  sel_axis_reg <= 2'd3;
    end
  end
  assign selected_axis = sel_axis_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      step_prev_reg <= 1'b1;
    else
      step_prev_reg <= s_step;
  end
  // step input is active low; a falling edge advances one step
  assign ext_step_advance = ext_step_mode_en & step_prev_reg & ~s_step;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pulse_prev_reg <= '0;
    else
      pulse_prev_reg <= pulse_active;
  end

  logic [AXES-1:0] drive_flag, err_flag, inpos_ok;
  logic [AXES-1:0] soft_pos_hit, soft_neg_hit;
  logic [15:0]     stat1 [AXES];
  logic [15:0]     stat2 [AXES];

  for (genvar a = 0; a < AXES; a++)
  begin : g_axis
    logic signed [POS_W-1:0] pos, cpos, cneg;
    logic hlim_p, hlim_n, alarm, emergency_flag, restart;
    assign pos  = position[a*POS_W +: POS_W];
    assign cpos = comp_pos[a*POS_W +: POS_W];
    assign cneg = comp_neg[a*POS_W +: POS_W];
    assign inpos_ok[a] = s_inpos[a] == inpos_active_high[a];
    assign hlim_p = s_plim[a] == limit_active_high[a];
    assign hlim_n = s_nlim[a] == limit_active_high[a];
    assign alarm  = alarm_check_en[a] &&
                    (s_alarm[a] == alarm_active_high[a]);
    assign emergency_flag    = !s_emg_n;
    assign restart = drive_start[a] || clear_hit[a];
    assign soft_pos_hit[a] = soft_limit_en[a] && pulse_active[a] &&
                             !drive_dir_neg[a] && pos >= cpos;
    assign soft_neg_hit[a] = soft_limit_en[a] && pulse_active[a] &&
                             drive_dir_neg[a] && pos <= cneg;

    always_ff @(posedge clk)
    begin
      if (!rst_n)
        inpos_wait_reg[a] <= 1'b0;
      else if (pulse_prev_reg[a] && !pulse_active[a] &&
               inpos_check_en[a] && !inpos_ok[a])
        inpos_wait_reg[a] <= 1'b1;
      else if (inpos_ok[a] || !inpos_check_en[a] || pulse_active[a])
        inpos_wait_reg[a] <= 1'b0;
    end
    assign drive_flag[a] = pulse_active[a] || home_active[a] ||
                           inpos_wait_reg[a];

    // finish causes caught at the stop; a stop beats a clear in one cycle
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        cause_reg[a] <= '0;
      else if (drive_stop[a])
        cause_reg[a] <= cause_reg[a] |
          {emergency_flag, alarm, hlim_n, hlim_p, ~s_decel[4*a +: 4]};
      else if (restart)
        cause_reg[a] <= '0;
    end

    // bits 0,1 soft limits, 2..5 latched pins, 7 home error
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        err_reg[a] <= '0;
      else
      begin
        err_reg[a][0] <= soft_pos_hit[a] ||
          (err_reg[a][0] && !drive_dir_neg[a] && !restart);
        err_reg[a][1] <= soft_neg_hit[a] ||
          (err_reg[a][1] && (drive_dir_neg[a] || !pulse_active[a]) &&
           !restart);
        err_reg[a][5:2] <= {emergency_flag, alarm, hlim_n, hlim_p} |
          (restart ? 4'h0 : err_reg[a][5:2]);
        err_reg[a][6] <= 1'b0;
        err_reg[a][7] <= (home_step3_start[a] && !s_index[a]) ||
          (err_reg[a][7] && !restart);
      end
    end
    assign limit_stop_req[a] = pulse_active[a] &&
      (soft_pos_hit[a] || soft_neg_hit[a] ||
       (hlim_p && !drive_dir_neg[a]) || (hlim_n && drive_dir_neg[a]));

    assign err_flag[a] = |err_reg[a] | |cause_reg[a][7:4];
    assign stat1[a] = {cause_reg[a], accel_decreasing[a],
                       7'h00};
    assign stat2[a] = {3'b000, home_search_state[5*a +: 5],
                       err_reg[a]};
  end

  logic [15:0] main_word;
  assign main_word = {1'b0, stack_count,
                      circle_octant,
                      next_node_ready, interp_active,
                      err_flag, drive_flag};

  // read data is captured in the setup phase and held for access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
    begin
      unique case (paddr)
        micfg_pkg::OFF_MAIN_STATUS: prdata_reg <= {16'h0000, main_word};
        micfg_pkg::OFF_AXIS_STAT1:
          prdata_reg <= {16'h0000, stat1[sel_axis_reg]};
        micfg_pkg::OFF_AXIS_STAT2:
          prdata_reg <= {16'h0000, stat2[sel_axis_reg]};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  sequence s_mode_write;
    wr_en && paddr == micfg_pkg::OFF_INTERP_MODE;
  endsequence

  property p_mode_reset;
    @(posedge clk) !rst_n |=> interp_mode_reg == 16'h0000;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode register not cleared by reset");

  property p_master_field;
    @(posedge clk) disable iff (!rst_n)
    s_mode_write |=> master_axis_sel == $past(pwdata[1:0]) &&
                     third_axis_sel == $past(pwdata[5:4]);
  endproperty
  a_master_field: assert property (p_master_field)
    else $error("axis select fields not taken from write");

  property p_vspeed_illegal;
    @(posedge clk) disable iff (!rst_n)
    (s_mode_write ##0 bad_vspeed) |=>
      $stable(vector_speed_mode) && vector_speed_mode != 2'b10;
  endproperty
  a_vspeed_illegal: assert property (p_vspeed_illegal)
    else $error("illegal vector speed code accepted");

  property p_halves_independent;
    @(posedge clk) disable iff (!rst_n)
    (wr_en && paddr == micfg_pkg::OFF_DATA_LOW) |=>
      cmd_operand[15:0] == $past(pwdata[15:0]) &&
      cmd_operand[31:16] == $past(cmd_operand[31:16]);
  endproperty
  a_halves_independent: assert property (p_halves_independent)
    else $error("low half write disturbed high half");

  sequence s_pulse_end_unsettled;
    pulse_active[0] ##1 (!pulse_active[0] && !home_active[0] &&
                         inpos_check_en[0] && !inpos_ok[0]);
  endsequence

  property p_inpos_hold;
    @(posedge clk) disable iff (!rst_n)
    s_pulse_end_unsettled |=> drive_flag[0];
  endproperty
  a_inpos_hold: assert property (p_inpos_hold)
    else $error("drive flag fell before in-position");

  property p_cause_holds;
    @(posedge clk) disable iff (!rst_n)
    (cause_reg[0] != 8'h00 && !drive_start[0] && !clear_hit[0]) |=>
      cause_reg[0] == $past(cause_reg[0]) || drive_stop[0] ||
      $past(drive_stop[0]);
  endproperty
  a_cause_holds: assert property (p_cause_holds)
    else $error("finish cause lost without a clear");

  property p_soft_reverse;
    @(posedge clk) disable iff (!rst_n)
    (pulse_active[0] && drive_dir_neg[0]) |=> !err_reg[0][0];
  endproperty
  a_soft_reverse: assert property (p_soft_reverse)
    else $error("positive soft limit set in reverse drive");

  property p_home_error;
    @(posedge clk) disable iff (!rst_n)
    (home_step3_start[1] && !s_index[1]) |=> err_reg[1][7] ##0
      err_flag[1];
  endproperty
  a_home_error: assert property (p_home_error)
    else $error("home error not raised at step three");

  property p_emg_error;
    @(posedge clk) disable iff (!rst_n)
    !s_emg_n |=> err_reg[2][5] && err_flag[2];
  endproperty
  a_emg_error: assert property (p_emg_error)
    else $error("emergency not reported as axis error");

endmodule : micfg_regs
`default_nettype wire

// ==== micfg_apb_host.sv ====
// apb host model that stands in for the processor on the register bus
`timescale 1ns/1ps
`default_nettype none
module micfg_apb_host (
  input  wire logic        clk,     // bus clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // write
  output logic [7:0]       paddr,   // byte address
  output logic [31:0]      pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error response
);
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // request stands until pready is seen high, then bus lines are scrambled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : micfg_apb_host
`default_nettype wire

// ==== tb_micfg_regs.sv ====
// testbench for the interpolation config and status register group
`timescale 1ns/1ps
`default_nettype none
module tb_micfg_regs;
  logic         clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, cmd_operand;
  logic [3:0]   in_position_in, servo_alarm_in, pos_limit_in, neg_limit_in;
  logic [3:0]   encoder_index_in, inpos_check_en, inpos_active_high;
  logic [3:0]   alarm_check_en, alarm_active_high, limit_active_high;
  logic [3:0]   soft_limit_en, pulse_active, home_active, drive_dir_neg;
  logic [3:0]   drive_start, drive_stop, home_step3_start, accel_decreasing;
  logic [3:0]   limit_stop_req;
  logic [15:0]  decel_stop_inputs;
  logic [19:0]  home_search_state;
  logic [127:0] position, comp_pos, comp_neg;
  logic         emergency_in_n, ext_step_pulse_in, bus_8bit_in;
  logic         interp_active, next_node_ready, ext_step_mode_en;
  logic         cmd_step_mode_en, interp_irq_en, bitpat_irq_en;
  logic         ext_step_advance;
  logic [2:0]   circle_octant;
  logic [1:0]   stack_count, master_axis_sel, second_axis_sel;
  logic [1:0]   third_axis_sel, vector_speed_mode, selected_axis;
  int           mismatches = 0, tests_run = 0, cycles = 0;

  micfg_regs i_micfg_regs (.*);
  micfg_apb_host i_micfg_apb_host (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    logic [31:0] rd;
    logic        err;
    i_micfg_apb_host.xfer(w, a, d, rd, err);
    chk({31'h0000_0000, err}, {31'h0000_0000, e});
    if (!w)
      chk(rd, d);
  endtask : acc
  task automatic rd1(input logic [7:0] a, input logic [31:0] d);
    acc(1'b0, a, d, 1'b0);
  endtask : rd1
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    logic [15:0] v;
    rst_n = 1'b0;
    {in_position_in, servo_alarm_in, pos_limit_in, neg_limit_in} = '0;
    {inpos_check_en, inpos_active_high, alarm_check_en} = '0;
    {alarm_active_high, soft_limit_en, pulse_active, home_active} = '0;
    {drive_dir_neg, drive_start, drive_stop, home_step3_start} = '0;
    {accel_decreasing, home_search_state, position, comp_pos} = '0;
    {comp_neg, bus_8bit_in, interp_active, next_node_ready} = '0;
    {circle_octant, stack_count} = '0;
    {emergency_in_n, ext_step_pulse_in} = 2'h3;
    {encoder_index_in, limit_active_high} = 8'hFF;
    decel_stop_inputs = 16'hFFFF;
    tick(20);
    rst_n <= 1'b1;
    tick(3);
    chk({20'h0_0000, bitpat_irq_en, interp_irq_en, cmd_step_mode_en,
         ext_step_mode_en, vector_speed_mode, third_axis_sel,
         second_axis_sel, master_axis_sel}, 32'h0000_0000);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0000);
    $display("test done: reset");
    for (int i = 0; i < 4; i++)
    begin
      v = {i[0], i[1], 1'b0, i[1], i[0], 1'b0,
           (i == 2) ? 2'h3 : {1'b0, i[0]}, 2'h0, i[1:0], ~i[1:0], i[1:0]};
      acc(1'b1, micfg_pkg::OFF_INTERP_MODE, {16'h0000, v}, 1'b0);
      tick(1);
      chk({20'h0_0000, bitpat_irq_en, interp_irq_en, cmd_step_mode_en,
           ext_step_mode_en, vector_speed_mode, third_axis_sel,
           second_axis_sel, master_axis_sel},
          {20'h0_0000, v[15:14], v[12:11], v[9:8], v[5:0]});
    end
    // forbidden speed code keeps the previous one
    acc(1'b1, micfg_pkg::OFF_INTERP_MODE, 32'h0000_0200, 1'b1);
    tick(1);
    chk({28'h000_0000, vector_speed_mode, master_axis_sel},
        32'h0000_0004);
    acc(1'b1, micfg_pkg::OFF_INTERP_MODE, 32'h0000_0800, 1'b0);
    ext_step_pulse_in <= 1'b0;
    tick(3);
    chk({31'h0000_0000, ext_step_advance}, 32'h0000_0001);
    tick(1);
    chk({31'h0000_0000, ext_step_advance}, 32'h0000_0000);
    ext_step_pulse_in <= 1'b1;
    $display("test done: mode");
    acc(1'b1, micfg_pkg::OFF_DATA_HIGH, 32'h0000_FFFF, 1'b0);
    acc(1'b1, micfg_pkg::OFF_DATA_LOW, 32'h0000_FFFE, 1'b0);
    tick(1);
    chk(cmd_operand, 32'hFFFF_FFFE);
    bus_8bit_in <= 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b1, 8'(micfg_pkg::OFF_DLOW_BYTE0 + 4 * i),
          {24'h00_0000, 8'(8'h78 - 8'h22 * i)}, 1'b0);
    tick(1);
    chk(cmd_operand, 32'h1234_5678);
    bus_8bit_in <= 1'b0;
    acc(1'b1, micfg_pkg::OFF_DLOW_BYTE0, 32'h0000_0000, 1'b1);
    $display("test done: data");
    pulse_active <= 4'h5;
    for (int k = 0; k < 8; k++)
    begin
      {next_node_ready, interp_active} <= k[1:0];
      circle_octant <= k[2:0];
      stack_count <= k[1:0];
      tick(4);
      rd1(micfg_pkg::OFF_MAIN_STATUS,
          {17'h0_0000, k[1:0], k[2:0], k[1:0], 8'h05});
    end
    {interp_active, next_node_ready, circle_octant, stack_count} <= '0;
    {inpos_check_en, inpos_active_high} <= 8'h11;
    pulse_active <= 4'h0;
    home_active <= 4'h2;
    tick(4);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0003);
    in_position_in <= 4'h1;
    home_active <= 4'h0;
    tick(4);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0000);
    $display("test done: main status");
    accel_decreasing <= 4'h4;
    home_search_state <= 20'h0_4C00;
    acc(1'b1, micfg_pkg::OFF_COMMAND, 32'h0000_0C1F, 1'b0);
    tick(4);
    chk({30'h0000_0000, selected_axis}, 32'h0000_0002);
    rd1(micfg_pkg::OFF_AXIS_STAT1, 32'h0000_0080);
    rd1(micfg_pkg::OFF_AXIS_STAT2, 32'h0000_1300);
    acc(1'b1, micfg_pkg::OFF_COMMAND, 32'h0000_011F, 1'b0);
    rd1(micfg_pkg::OFF_AXIS_STAT1, 32'h0000_0000);
    $display("test done: axis select");
    pulse_active <= 4'h1;
    pos_limit_in <= 4'h1;
    tick(4);
    drive_stop <= 4'h1;
    pulse_active <= 4'h0;
    tick(1);
    drive_stop <= 4'h0;
    tick(4);
    rd1(micfg_pkg::OFF_AXIS_STAT1, 32'h0000_1000);
    rd1(micfg_pkg::OFF_AXIS_STAT2, 32'h0000_0004);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0010);
    pos_limit_in <= 4'h0;
    tick(4);
    rd1(micfg_pkg::OFF_AXIS_STAT1, 32'h0000_1000);
    acc(1'b1, micfg_pkg::OFF_COMMAND, 32'h0000_0125, 1'b0);
    tick(2);
    rd1(micfg_pkg::OFF_AXIS_STAT1, 32'h0000_0000);
    rd1(micfg_pkg::OFF_AXIS_STAT2, 32'h0000_0000);
    $display("test done: finish causes");
    soft_limit_en <= 4'h1;
    pulse_active <= 4'h1;
    tick(1);
    chk({28'h000_0000, limit_stop_req}, 32'h0000_0001);
    {soft_limit_en, pulse_active} <= '0;
    emergency_in_n <= 1'b0;
    encoder_index_in <= 4'hD;
    tick(3);
    home_step3_start <= 4'h2;
    tick(1);
    home_step3_start <= 4'h0;
    rd1(micfg_pkg::OFF_AXIS_STAT2, 32'h0000_0021);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_00F0);
    acc(1'b1, micfg_pkg::OFF_COMMAND, 32'h0000_021F, 1'b0);
    rd1(micfg_pkg::OFF_AXIS_STAT2, 32'h0000_00A0);
    emergency_in_n <= 1'b1;
    encoder_index_in <= 4'hF;
    tick(3);
    acc(1'b1, micfg_pkg::OFF_COMMAND, 32'h0000_0F25, 1'b0);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0000);
    $display("test done: errors");
    acc(1'b0, 8'h40, 32'h0000_0000, 1'b1);
    acc(1'b1, micfg_pkg::OFF_MAIN_STATUS, 32'h0000_FFFF, 1'b0);
    rd1(micfg_pkg::OFF_MAIN_STATUS, 32'h0000_0000);
    $display("test done: refusals");
    wrap_up();
  end
endmodule : tb_micfg_regs
`default_nettype wire
